//--- hw/ppbs_pkg.sv
// shared constants, encodings and carriers for the processor pre-boot sequencer
package ppbs_pkg;

	// =====================================================================
	// register map (byte addresses on the apb side)
	localparam logic [7:0] PPBS_STATUS_ADDR = 8'h00;
	localparam logic [7:0] PPBS_CONTROL_ADDR = 8'h04;
	localparam logic [7:0] PPBS_VECTOR_BASE_ADDR = 8'h08;
	localparam int PPBS_VECTOR_COUNT = 5;
	localparam logic [7:0] PPBS_LAST_ADDR = 8'h18;

	// =====================================================================
	// field positions and reset values
	localparam int PPBS_CTRL_DEBUG_ATTACHED_BIT = 0;
	localparam logic [31:0] PPBS_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] PPBS_VECTOR_RESET = 32'h0000_0000;
	localparam logic [31:0] PPBS_BOOT_ROM_BASE = 32'h0000_0000;
	localparam logic [31:0] PPBS_SCRATCH_BASE = 32'h0100_0000;

	// =====================================================================
	// configuration blob layout, in 32-bit words, little endian bytes
	localparam int PPBS_BLOB_WORDS = 6;
	localparam int PPBS_BLOB_START_PAGE_WORD = 0;
	localparam int PPBS_BLOB_CERT_ADDR_WORD = 0;
	localparam int PPBS_BLOB_REVOKE_WORD = 1;
	localparam int PPBS_BLOB_KEY_FIRST_WORD = 1;
	localparam int PPBS_BLOB_VEC0_WORD = 0;
	localparam int PPBS_BLOB_VEC1_WORD = 1;
	localparam int PPBS_BLOB_VEC2_WORD = 2;
	localparam int PPBS_BLOB_VEC3_WORD = 4;
	localparam int PPBS_BLOB_VEC4_WORD = 5;

	// =====================================================================
	// encodings
	typedef enum logic [1:0] {
		PPBS_MODE_IDLE = 2'h0,
		PPBS_MODE_NONSECURE = 2'h1,
		PPBS_MODE_USER_SECURE = 2'h2,
		PPBS_MODE_FACTORY_SECURE = 2'h3
	} ppbs_mode_type;

	typedef enum logic [2:0] {
		PPBS_TASK_NONE = 3'h0,
		PPBS_TASK_FLASH_POWER = 3'h1,
		PPBS_TASK_CACHE_REPAIR = 3'h2,
		PPBS_TASK_COPY_USER = 3'h3,
		PPBS_TASK_AUTH_USER = 3'h4,
		PPBS_TASK_CERT_CHECK = 3'h5,
		PPBS_TASK_COPY_FACTORY = 3'h6,
		PPBS_TASK_SIG_CHECK = 3'h7
	} ppbs_task_type;

	typedef enum logic [3:0] {
		PPBS_ST_WAIT_INIT = 4'h0,
		PPBS_ST_FLASH_UP = 4'h1,
		PPBS_ST_CACHE_REPAIR = 4'h2,
		PPBS_ST_COPY_USER = 4'h3,
		PPBS_ST_AUTH_USER = 4'h4,
		PPBS_ST_CERT_CHECK = 4'h5,
		PPBS_ST_COPY_FACTORY = 4'h6,
		PPBS_ST_SIG_CHECK = 4'h7,
		PPBS_ST_RELEASED = 4'h8,
		PPBS_ST_HELD = 4'h9,
		PPBS_ST_SKIPPED = 4'ha
	} ppbs_state_type;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ppbs_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ppbs_apb_rsp_type;

	typedef struct packed {
		logic load;
		logic [2:0] index;
		logic [31:0] word;
		logic commit;
		ppbs_mode_type mode;
	} ppbs_cfg_type;

	typedef struct packed {
		logic req;
		ppbs_task_type code;
		logic [31:0] arg;
		logic [95:0] key;
	} ppbs_task_req_type;

	typedef struct packed {
		logic done;
		logic ok;
	} ppbs_task_rsp_type;

endpackage

//--- hw/ppbs_sequencer.sv
// processor pre-boot sequencer with apb status/control registers
// =====================================================================
// What this block does
// - start only after design initialization completes
// - early parts in suspend skip pre-boot
// - flash power, cache repair, authenticate, hand over
// - decode two-bit mode: idle/nonsecure/user/factory
// - idle or unconfigured: spin until debugger attaches
// - vectors persist until reset or reprogramming
// - idle mode ignores the configuration blob
// - nonsecure boot runs without any authentication
// - nonsecure vectors from blob bytes 0,4,8,16,20
// - nonsecure address may point into fabric
// - user secure copies code into scratch memory
// - user authentication failure holds reset, flags tamper
// - user blob: page byte 0, key byte 4
// - factory: validate certificate before copying code
// - signature ok releases, error holds plus tamper
// - factory failure drives tamper flag to fabric
// - certificate checked by engine at given address
// - factory blob: certificate address, revocation word
// - mode changes only by reprogramming, not writes
// - successful pre-boot releases core complex reset
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module ppbs_sequencer
	import ppbs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire ppbs_apb_req_type apb_req,
	output ppbs_apb_rsp_type apb_rsp,
	input wire ppbs_cfg_type cfg,
	input wire logic design_init_done,
	input wire logic early_sample_part,
	input wire logic controller_suspend,
	output ppbs_task_req_type task_req,
	input wire ppbs_task_rsp_type task_rsp,
	output logic core_reset_n,
	output logic boot_fail_tamper,
	output logic boot_rom_spin,
	output logic certificate_revocation_enable,
	output logic [PPBS_VECTOR_COUNT-1:0][31:0] hart_vectors
);

	// =====================================================================
	// state
	typedef struct packed {
		ppbs_state_type st;
		ppbs_mode_type mode;
		logic configured;
		logic [PPBS_BLOB_WORDS-1:0][31:0] blob;
		logic [PPBS_VECTOR_COUNT-1:0][31:0] vec;
		logic rst_n;
		logic fail;
		logic spin;
		logic revoke;
		logic dbg;
		ppbs_task_req_type tk;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} ppbs_regs_type;

	ppbs_regs_type state_reg;
	ppbs_regs_type state_next;
	logic access;
	logic mapped;
	logic [31:0] read_word;
	logic [2:0] vec_index;

	// apb decode; every mapped offset is word aligned
	assign access = apb_req.psel && apb_req.penable;
	assign vec_index = 3'((apb_req.paddr - PPBS_VECTOR_BASE_ADDR) >> 2);
	assign mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= PPBS_LAST_ADDR);

	// read mux; status shows state, mode and outcome flags
	always_comb
	begin
		read_word = 32'h0000_0000;
		if (apb_req.paddr == PPBS_STATUS_ADDR)
			read_word = {20'h0_0000, state_reg.rst_n, state_reg.fail, state_reg.spin, state_reg.configured,
				2'(state_reg.mode), 2'h0, 4'(state_reg.st)};
		else if (apb_req.paddr == PPBS_CONTROL_ADDR)
			read_word = {31'h0000_0000, state_reg.dbg};
		else if (mapped)
			read_word = state_reg.vec[vec_index];
	end

	// next-state logic for bus, blob store and sequencer
	always_comb
	begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		// one wait state so read data comes straight from a flop
		if (access && !state_reg.ack)
		begin
			state_next.ack = 1'b1;
			state_next.err = !mapped;
			state_next.rdata = mapped ? read_word : 32'h0000_0000;
		end
		// only the debug bit is writable; the mode is never touched here
		if (access && state_reg.ack && apb_req.pwrite && apb_req.paddr == PPBS_CONTROL_ADDR)
			state_next.dbg = apb_req.pwdata[PPBS_CTRL_DEBUG_ATTACHED_BIT];
		if (state_next.dbg)
			state_next.spin = 1'b0;
		if (cfg.load && cfg.index < 3'(PPBS_BLOB_WORDS))
			state_next.blob[cfg.index] = cfg.word;
		// a finished task that reports an error ends in hold
		if (state_reg.tk.req && task_rsp.done)
		begin
			state_next.tk.req = 1'b0;
			if (!task_rsp.ok)
			begin
				state_next.st = PPBS_ST_HELD;
				state_next.fail = 1'b1;
			end
		end
		unique case (state_reg.st)
			PPBS_ST_WAIT_INIT:
				if (design_init_done)
				begin
					if (early_sample_part && controller_suspend)
						state_next.st = PPBS_ST_SKIPPED;
					else
					begin
						state_next.st = PPBS_ST_FLASH_UP;
						state_next.tk.req = 1'b1;
						state_next.tk.code = PPBS_TASK_FLASH_POWER;
					end
				end
			PPBS_ST_FLASH_UP:
				if (task_rsp.done && task_rsp.ok)
				begin
					state_next.st = PPBS_ST_CACHE_REPAIR;
					state_next.tk.req = 1'b1;
					state_next.tk.code = PPBS_TASK_CACHE_REPAIR;
				end
			PPBS_ST_CACHE_REPAIR:
				if (task_rsp.done && task_rsp.ok)
				begin
					state_next.tk.req = 1'b1;
					unique case (state_reg.configured ? state_reg.mode : PPBS_MODE_IDLE)
						PPBS_MODE_IDLE:
						begin
							// blob unused; every hart spins in the boot rom loop
							state_next.tk.req = 1'b0;
							state_next.st = PPBS_ST_RELEASED;
							state_next.vec = {PPBS_VECTOR_COUNT{PPBS_BOOT_ROM_BASE}};
							state_next.spin = !state_next.dbg; // a same-cycle debug write wins
							state_next.rst_n = 1'b1;
						end
						PPBS_MODE_NONSECURE:
						begin
							// no check at all; the address may equally sit in fabric
							state_next.tk.req = 1'b0;
							state_next.st = PPBS_ST_RELEASED;
							state_next.vec[0] = state_reg.blob[PPBS_BLOB_VEC0_WORD];
							state_next.vec[1] = state_reg.blob[PPBS_BLOB_VEC1_WORD];
							state_next.vec[2] = state_reg.blob[PPBS_BLOB_VEC2_WORD];
							state_next.vec[3] = state_reg.blob[PPBS_BLOB_VEC3_WORD];
							state_next.vec[4] = state_reg.blob[PPBS_BLOB_VEC4_WORD];
							state_next.rst_n = 1'b1;
						end
						PPBS_MODE_USER_SECURE:
						begin
							state_next.st = PPBS_ST_COPY_USER;
							state_next.tk.code = PPBS_TASK_COPY_USER;
							state_next.tk.arg = {24'h00_0000, state_reg.blob[PPBS_BLOB_START_PAGE_WORD][7:0]};
							// one key serves every protected page
							state_next.tk.key = {state_reg.blob[PPBS_BLOB_KEY_FIRST_WORD+2],
								state_reg.blob[PPBS_BLOB_KEY_FIRST_WORD+1],
								state_reg.blob[PPBS_BLOB_KEY_FIRST_WORD]};
						end
						PPBS_MODE_FACTORY_SECURE:
						begin
							state_next.st = PPBS_ST_CERT_CHECK;
							state_next.tk.code = PPBS_TASK_CERT_CHECK;
							state_next.tk.arg = state_reg.blob[PPBS_BLOB_CERT_ADDR_WORD];
							state_next.revoke = state_reg.blob[PPBS_BLOB_REVOKE_WORD] != 32'h0000_0000;
						end
					endcase
				end
			PPBS_ST_COPY_USER:
				if (task_rsp.done && task_rsp.ok)
				begin
					state_next.st = PPBS_ST_AUTH_USER;
					state_next.tk.req = 1'b1;
					state_next.tk.code = PPBS_TASK_AUTH_USER;
				end
			PPBS_ST_CERT_CHECK:
				if (task_rsp.done && task_rsp.ok)
				begin
					state_next.st = PPBS_ST_COPY_FACTORY;
					state_next.tk.req = 1'b1;
					state_next.tk.code = PPBS_TASK_COPY_FACTORY;
				end
			PPBS_ST_COPY_FACTORY:
				if (task_rsp.done && task_rsp.ok)
				begin
					state_next.st = PPBS_ST_SIG_CHECK;
					state_next.tk.req = 1'b1;
					state_next.tk.code = PPBS_TASK_SIG_CHECK;
				end
			PPBS_ST_AUTH_USER, PPBS_ST_SIG_CHECK:
				if (task_rsp.done && task_rsp.ok)
				begin
					// monitor core starts from its scratch memory
					state_next.st = PPBS_ST_RELEASED;
					state_next.vec = {PPBS_VECTOR_COUNT{PPBS_SCRATCH_BASE}};
					state_next.rst_n = 1'b1;
				end
			PPBS_ST_RELEASED, PPBS_ST_HELD, PPBS_ST_SKIPPED:
				state_next.tk.req = 1'b0;
			default:
				state_next.st = PPBS_ST_HELD;
		endcase
		// reprogramming is the only route to a new mode; it restarts the sequence but keeps the blob and debug bit
		if (cfg.commit)
		begin
			state_next.mode = cfg.mode;
			state_next.configured = 1'b1;
			state_next.st = PPBS_ST_WAIT_INIT;
			state_next.vec = {PPBS_VECTOR_COUNT{PPBS_VECTOR_RESET}};
			state_next.rst_n = 1'b0;
			state_next.fail = 1'b0;
			state_next.spin = 1'b0;
			state_next.revoke = 1'b0;
			state_next.tk.req = 1'b0;
		end
	end

	// the only flops of the block
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
			state_reg.st <= PPBS_ST_WAIT_INIT;
			state_reg.dbg <= PPBS_CONTROL_RESET[PPBS_CTRL_DEBUG_ATTACHED_BIT];
		end
		else
			state_reg <= state_next;
	end

	// outputs straight from flops
	assign apb_rsp = '{prdata: state_reg.rdata, pready: state_reg.ack, pslverr: state_reg.err};
	assign task_req = state_reg.tk;
	assign core_reset_n = state_reg.rst_n;
	assign boot_fail_tamper = state_reg.fail;
	assign boot_rom_spin = state_reg.spin;
	assign certificate_revocation_enable = state_reg.revoke;
	assign hart_vectors = state_reg.vec;

	// =====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_wait_init;
		state_reg.st == PPBS_ST_WAIT_INIT && !design_init_done && !cfg.commit |=> !task_req.req && !core_reset_n;
	endproperty
	a_wait_init: assert property (p_wait_init) else $error("pre-boot started before init");

	property p_skip;
		state_reg.st == PPBS_ST_WAIT_INIT && design_init_done && early_sample_part && controller_suspend
			&& !cfg.commit |=> state_reg.st == PPBS_ST_SKIPPED ##1 !task_req.req;
	endproperty
	a_skip: assert property (p_skip) else $error("suspend part did not skip");

	property p_order;
		state_reg.st == PPBS_ST_FLASH_UP && task_rsp.done && task_rsp.ok && !cfg.commit
			|=> task_req.req && task_req.code == PPBS_TASK_CACHE_REPAIR;
	endproperty
	a_order: assert property (p_order) else $error("cache repair did not follow flash");

	property p_nonsec_vec;
		state_reg.st == PPBS_ST_CACHE_REPAIR && task_rsp.done && task_rsp.ok && state_reg.configured
			&& state_reg.mode == PPBS_MODE_NONSECURE && !cfg.commit
			|=> core_reset_n && hart_vectors[3] == $past(state_reg.blob[4]) && hart_vectors[4] == $past(state_reg.blob[5]);
	endproperty
	a_nonsec_vec: assert property (p_nonsec_vec) else $error("nonsecure vectors wrong");

	property p_sig_fail;
		state_reg.st == PPBS_ST_SIG_CHECK && task_rsp.done && !task_rsp.ok && !cfg.commit
			|=> (boot_fail_tamper && !core_reset_n) [*2];
	endproperty
	a_sig_fail: assert property (p_sig_fail) else $error("signature failure not held");

	property p_held_reset;
		!(state_reg.st inside {PPBS_ST_RELEASED}) |-> !core_reset_n;
	endproperty
	a_held_reset: assert property (p_held_reset) else $error("reset released without decision");

	property p_mode_fixed;
		!cfg.commit |=> $stable(state_reg.mode);
	endproperty
	a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed without reprogramming");

	property p_page;
		state_reg.st == PPBS_ST_COPY_USER && task_req.req |-> task_req.arg[7:0] == state_reg.blob[0][7:0];
	endproperty
	a_page: assert property (p_page) else $error("start page wrong");

	property p_revoke;
		state_reg.st == PPBS_ST_CACHE_REPAIR && task_rsp.done && task_rsp.ok && state_reg.configured
			&& state_reg.mode == PPBS_MODE_FACTORY_SECURE && !cfg.commit
			|=> certificate_revocation_enable == ($past(state_reg.blob[1]) != 32'h0000_0000);
	endproperty
	a_revoke: assert property (p_revoke) else $error("revocation enable wrong");

	property p_vec_hold;
		state_reg.st == PPBS_ST_RELEASED && !cfg.commit |=> $stable(hart_vectors);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vectors changed after release");

	property p_idle_spin;
		state_reg.st == PPBS_ST_CACHE_REPAIR && task_rsp.done && task_rsp.ok
			&& (!state_reg.configured || state_reg.mode == PPBS_MODE_IDLE) && !cfg.commit
			|=> core_reset_n && boot_rom_spin == !state_reg.dbg
			&& hart_vectors == {PPBS_VECTOR_COUNT{PPBS_BOOT_ROM_BASE}};
	endproperty
	a_idle_spin: assert property (p_idle_spin) else $error("idle boot did not spin from boot rom");

	property p_user_fail;
		state_reg.st == PPBS_ST_AUTH_USER && task_req.req && task_rsp.done && !task_rsp.ok && !cfg.commit
			|=> boot_fail_tamper && !core_reset_n && state_reg.st == PPBS_ST_HELD;
	endproperty
	a_user_fail: assert property (p_user_fail) else $error("user authentication failure not held");

	property p_cert_first;
		state_reg.st == PPBS_ST_CERT_CHECK && task_rsp.done && !task_rsp.ok && !cfg.commit
			|=> state_reg.st == PPBS_ST_HELD && !task_req.req;
	endproperty
	a_cert_first: assert property (p_cert_first) else $error("factory code copied without certificate");

	property p_release_clean;
		$rose(core_reset_n) |-> !boot_fail_tamper && state_reg.st == PPBS_ST_RELEASED;
	endproperty
	a_release_clean: assert property (p_release_clean) else $error("reset released after failure");

	property p_commit_restart;
		cfg.commit |=> state_reg.st == PPBS_ST_WAIT_INIT && !core_reset_n && !boot_fail_tamper
			&& hart_vectors == {PPBS_VECTOR_COUNT{PPBS_VECTOR_RESET}};
	endproperty
	a_commit_restart: assert property (p_commit_restart) else $error("commit did not restart");

	c_nonsec: cover property (state_reg.mode == PPBS_MODE_NONSECURE && $rose(core_reset_n));
	c_user: cover property (state_reg.mode == PPBS_MODE_USER_SECURE && $rose(core_reset_n));
	c_factory_fail: cover property ($rose(boot_fail_tamper));
	c_skip: cover property (state_reg.st == PPBS_ST_SKIPPED);

endmodule

//--- test/ppbs_core_model.sv
// behavioural model of the core complex task engine facing the sequencer
`timescale 1ns/100ps
module ppbs_core_model
	import ppbs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire ppbs_task_req_type task_req,
	input wire ppbs_task_type fail_code,
	input wire logic [2:0] lag,
	output ppbs_task_rsp_type task_rsp
);
	logic [2:0] wait_reg;
	logic good_reg;
	// ==========================================================
	// answer a held request lag+1 cycles after it appears, one done pulse each
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			task_rsp <= '0;
			wait_reg <= '0;
			good_reg <= 1'b0;
		end
		else if (task_rsp.done || !task_req.req)
		begin
			task_rsp <= '{1'b0, !good_reg}; // ok flips outside done: no free pass
			wait_reg <= '0;
		end
		else if (wait_reg == lag)
		begin
			good_reg <= (task_req.code != fail_code);
			task_rsp <= '{1'b1, task_req.code != fail_code};
		end
		else
			wait_reg <= wait_reg + 3'h1;
	end
endmodule

//--- test/ppbs_sequencer_bench.sv
// self-checking bench for the processor pre-boot sequencer
`timescale 1ns/100ps
module ppbs_sequencer_bench
	import ppbs_pkg::*;
;
	typedef struct packed {ppbs_task_type code; logic [31:0] arg; logic [95:0] key;} ppbs_note_type;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	ppbs_apb_req_type apb_req = '0;
	ppbs_apb_rsp_type apb_rsp;
	ppbs_cfg_type cfg = '0;
	logic init_done = 1'b0;
	logic early = 1'b0;
	logic suspend = 1'b0;
	ppbs_task_req_type task_req;
	ppbs_task_rsp_type task_rsp;
	ppbs_task_type fail_code = PPBS_TASK_NONE;
	logic [2:0] lag = 3'h0;
	logic core_reset_n, tamper, spin, revoke;
	logic [PPBS_VECTOR_COUNT-1:0][31:0] vec;
	logic [31:0] seed = 32'h11ea;
	logic [32:0] aq[$];
	ppbs_note_type tq[$];
	int miscompares = 0;
	int compares = 0;

	always #10 pclk = ~pclk;

	ppbs_sequencer ppbs_sequencer_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.cfg(cfg), .design_init_done(init_done), .early_sample_part(early), .controller_suspend(suspend),
		.task_req(task_req), .task_rsp(task_rsp), .core_reset_n(core_reset_n), .boot_fail_tamper(tamper),
		.boot_rom_spin(spin), .certificate_revocation_enable(revoke), .hart_vectors(vec));
	ppbs_core_model ppbs_core_model_inst (.pclk(pclk), .presetn(presetn), .task_req(task_req),
		.fail_code(fail_code), .lag(lag), .task_rsp(task_rsp));

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] stat(logic r, logic f, logic s, logic c, logic [1:0] m, logic [3:0] st);
		return {20'h0, r, f, s, c, m, 2'h0, st};
	endfunction

	task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one apb transfer; reads note the expected answer first
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
		int n;
		if (!wr)
			aq.push_back(exp);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 20);
		apb_req <= '0;
		if (n >= 20)
		begin
			chk("apb timeout", 0, 1);
			print_verdict();
		end
	endtask

	task automatic cfg_pulse(input logic ld, input int i, input logic [31:0] w, input logic cm, input logic [1:0] m);
		@(posedge pclk);
		cfg <= '{ld, i[2:0], w, cm, ppbs_mode_type'(m)};
		@(posedge pclk);
		cfg <= '0;
	endtask

	// ==========================================================
	// monitors take the oldest note whenever a result shows
	always @(posedge pclk)
	begin
		if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0)
		begin
			chk("prdata", aq[0][32:1], apb_rsp.prdata);
			chk("pslverr", aq[0][0], apb_rsp.pslverr);
			void'(aq.pop_front());
		end
	end

	always @(posedge pclk)
	begin
		if (task_rsp.done === 1'b1 && task_req.req === 1'b1)
		begin
			chk("task code", tq[0].code, task_req.code);
			if (tq[0].code inside {PPBS_TASK_COPY_USER, PPBS_TASK_CERT_CHECK})
				chk("task arg", tq[0].arg, task_req.arg);
			if (tq[0].code == PPBS_TASK_COPY_USER)
				chk("task key", tq[0].key, task_req.key);
			void'(tq.pop_front());
		end
	end

	// ==========================================================
	// one boot in mode m, failing at task fc (none for success)
	task automatic run(input logic [1:0] m, input ppbs_task_type fc);
		logic [31:0] w[6];
		ppbs_task_type seq[5];
		logic good;
		logic stop;
		logic [31:0] ev;
		int n;
		for (int i = 0; i < 6; i++)
		begin
			w[i] = rnd();
			if (i == 1 && fc == PPBS_TASK_SIG_CHECK)
				w[i] = 32'h0;
			cfg_pulse(1'b1, i, w[i], 1'b0, 2'h0); // one page key for the whole image
		end
		fail_code <= fc;
		lag <= 3'(rnd());
		seq = '{PPBS_TASK_FLASH_POWER, PPBS_TASK_CACHE_REPAIR, PPBS_TASK_NONE, PPBS_TASK_NONE, PPBS_TASK_NONE};
		if (m == 2'h2)
		begin
			seq[2] = PPBS_TASK_COPY_USER;
			seq[3] = PPBS_TASK_AUTH_USER;
		end
		if (m == 2'h3)
		begin
			seq[2] = PPBS_TASK_CERT_CHECK;
			seq[3] = PPBS_TASK_COPY_FACTORY;
			seq[4] = PPBS_TASK_SIG_CHECK;
		end
		// nothing runs after the failing task
		stop = 1'b0;
		foreach (seq[i])
			if (seq[i] != PPBS_TASK_NONE && !stop)
			begin
				tq.push_back('{seq[i], m == 2'h2 ? {24'h0, w[0][7:0]} : w[0], {w[3], w[2], w[1]}});
				stop = (seq[i] == fc);
			end
		cfg_pulse(1'b0, 0, 32'h0, 1'b1, m);
		@(negedge pclk);
		chk("reset after commit", 0, core_reset_n);
		n = 0;
		while (core_reset_n !== 1'b1 && tamper !== 1'b1 && n < 500)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 500)
		begin
			chk("boot timeout", 0, 1);
			print_verdict();
		end
		@(negedge pclk);
		good = (fc == PPBS_TASK_NONE);
		chk("core_reset_n", good, core_reset_n);
		chk("tamper", !good, tamper);
		chk("spin", good && m == 2'h0, spin);
		chk("task queue empty", 0, tq.size());
		if (m == 2'h3)
			chk("revocation", w[1] != 32'h0, revoke);
		// a held boot keeps the vectors cleared by the commit
		for (int i = 0; i < 5; i++)
		begin
			ev = !good ? PPBS_VECTOR_RESET : m == 2'h0 ? PPBS_BOOT_ROM_BASE : m == 2'h1 ? w[i < 3 ? i : i + 1]
				: PPBS_SCRATCH_BASE;
			chk("vector", ev, vec[i]);
		end
		apb(1'b0, PPBS_VECTOR_BASE_ADDR + 8'h10, 32'h0, {ev, 1'b0});
		apb(1'b0, PPBS_STATUS_ADDR, 0, {stat(good, !good, good && m == 2'h0, 1'b1, m, good ? 4'h8 : 4'h9), 1'b0});
		if (m == 2'h1)
		begin
			cfg_pulse(1'b1, 0, ~w[0], 1'b0, 2'h0);
			chk("vector kept", w[0], vec[0]);
		end
		$display("test mode %0d fail %0d done", m, fc);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("held before init", 0, core_reset_n);
		apb(1'b0, PPBS_STATUS_ADDR, 0, 33'h0);
		apb(1'b1, PPBS_STATUS_ADDR, 32'hffff_ffff, 0);
		apb(1'b0, PPBS_STATUS_ADDR, 0, 33'h0);
		apb(1'b0, 8'h1c, 0, 33'h1);
		apb(1'b0, 8'h02, 0, 33'h1);
		// unconfigured boot still runs flash power and cache repair
		tq.push_back('{PPBS_TASK_FLASH_POWER, 32'h0, 96'h0});
		tq.push_back('{PPBS_TASK_CACHE_REPAIR, 32'h0, 96'h0});
		init_done <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b0, PPBS_STATUS_ADDR, 0, {stat(1, 0, 1, 0, 0, 8), 1'b0});
		apb(1'b1, PPBS_CONTROL_ADDR, 32'h1, 0);
		apb(1'b0, PPBS_CONTROL_ADDR, 0, {32'h1, 1'b0});
		chk("spin after debugger", 0, spin);
		apb(1'b1, PPBS_CONTROL_ADDR, 32'h0, 0);
		$display("test reset and idle done");
		for (int m = 0; m < 4; m++)
			run(m[1:0], PPBS_TASK_NONE);
		run(2'h2, PPBS_TASK_AUTH_USER);
		run(2'h3, PPBS_TASK_CERT_CHECK);
		run(2'h3, PPBS_TASK_SIG_CHECK);
		early <= 1'b1;
		suspend <= 1'b1;
		cfg_pulse(1'b0, 0, 32'h0, 1'b1, 2'h1);
		repeat (30) @(posedge pclk);
		chk("skipped held", 0, core_reset_n);
		apb(1'b0, PPBS_STATUS_ADDR, 0, {stat(0, 0, 0, 1, 1, 10), 1'b0});
		repeat (4) @(posedge pclk);
		$display("test skip done");
		print_verdict();
	end
endmodule
